// ==== rdwb_cfg.svh ====
// Constants for the receive descriptor write-back formatter.
// Assumes inclusion by the package and the design modules.
`ifndef RDWB_CFG_SVH
`define RDWB_CFG_SVH
`define RDWB_ST_DONE       0
`define RDWB_ST_LAST       1
`define RDWB_ST_TAGP       2
`define RDWB_ST_CHKD       3
`define RDWB_ST_FCS        4
`define RDWB_ST_CLS_LO     9
`define RDWB_ST_FLT_LO     12
`define RDWB_ST_LOCAL      14
`define RDWB_ST_V6ALT      15
`define RDWB_ST_UDP0       18
`define RDWB_ER_IP         3
`define RDWB_ER_L4         4
`define RDWB_ER_OVER       6
`define RDWB_ER_RSV        5
`define RDWB_ER_TOP        7
`define RDWB_CLS_UNI       2'h0
`define RDWB_CLS_MULTI     2'h1
`define RDWB_CLS_BCAST     2'h2
`define RDWB_FLT_NONE      2'h0
`define RDWB_FLT_HASH      2'h3
`define RDWB_MAX_DESC      3'h5
`define RDWB_KIND_RSV      8'h00
`define RDWB_KIND_IGNORE   8'h0C
`define RDWB_LEN_ZERO      14'h0000
`define RDWB_QW1_ERR_LO    19
`define RDWB_QW1_KIND_LO   30
`define RDWB_QW1_LEN_LO    38
`define RDWB_QW0_TAG_LO    16
`define RDWB_QW0_FLT_LO    32
`endif

// ==== rdwb_pkg.sv ====
// Types for the receive descriptor write-back formatter.
// Assumes rdwb_cfg.svh supplies the constants.
`include "rdwb_cfg.svh"
package rdwb_pkg;
	// Per-buffer request from the receive datapath
	typedef struct packed {
		logic        last;       // Buffer ends the packet
		logic        dummy;      // Spare descriptor, no data
		logic        fmt32;      // 32-byte ring
		logic [13:0] byte_count;
	} rdwb_buf_s;
	// Packet-level attributes, valid with the last buffer
	typedef struct packed {
		logic        tag_stripped;
		logic [15:0] tag;
		logic [15:0] tag2;
		logic        is_ip;
		logic        is_v6;
		logic        checks_done;
		logic        ip_sum_bad;
		logic        l4_bad;
		logic        rx_err;
		logic        fcs_remove;
		logic        local_hw_fcs;
		logic        is_local;
		logic [1:0]  dest_class;
		logic        hash_hit;
		logic [31:0] hash_sig;
		logic        v6_ext_outer;
		logic        v6_ext_inner;
		logic        is_udp;
		logic        udp_sum_zero;
		logic [7:0]  kind;
	} rdwb_pkt_s;
	// Descriptor handed to the memory writer
	typedef struct packed {
		logic        fmt32;
		logic [63:0] qw0;
		logic [63:0] qw1;
		logic [63:0] qw2;
		logic [63:0] qw3;
	} rdwb_desc_s;
	typedef enum logic [0:0] {
		RDWB_IDLE = 1'b0,
		RDWB_DROP = 1'b1
	} rdwb_state_e;
endpackage : rdwb_pkg

// ==== rdwb_skid.sv ====
// Two-entry buffer for formatted descriptors.
// Assumes one clock and the synchronised reset.
module rdwb_skid (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Fill side
	input  wire logic                 in_valid,
	output logic                      in_ready,
	input  wire rdwb_pkg::rdwb_desc_s in_data,
	// Drain side
	output logic                      out_valid,
	input  wire logic                 out_ready,
	output rdwb_pkg::rdwb_desc_s      out_data
);
	rdwb_pkg::rdwb_desc_s mem [2];
	rdwb_pkg::rdwb_desc_s next_mem [2];
	logic                 wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [1:0]           count, next_count;
	logic                 push, pop;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_mem    = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_mem[wr_ptr] = in_data;
			next_wr_ptr      = ~wr_ptr;
		end
		if (pop)
			next_rd_ptr = ~rd_ptr;
		if (push && !pop)
			next_count = count + 2'h1;
		else if (pop && !push)
			next_count = count - 2'h1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem[0] <= '0;
			mem[1] <= '0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			mem    <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	a_skid_order: assert property (
		@(posedge clk) disable iff (!rst_n)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("buffered descriptor changed while stalled");
endmodule : rdwb_skid

// ==== rdwb_top.sv ====
// Receive descriptor write-back formatter.
// Assumes the datapath presents one buffer per handshake, in ring order.
//
// Overview of operation
// - every descriptor of a packet carries done, last flag and byte count (zero for a spare descriptor)
// - other fields are filled only in the packet's final descriptor
// - status bit 0 marks the descriptor done by hardware
// - status bit 1 set only in the descriptor ending the packet
// - stripped tag sets bit 2 and fills the 16-bit tag field
// - status bit 3 set for IP packets whose checks ran
// - bit 4 marks kept FCS; receive error forces FCS kept except on hardware-FCS loopback
// - local loopback with hardware FCS never keeps FCS bytes
// - status bits 8 to 5 written as zero
// - dest class 00 unicast, 01 multicast, 10 broadcast, never 11
// - hash hit writes selector 11 and signature word
// - hash miss writes selector 00 and zero filter word
// - status bit 14 marks locally originated packets
// - bit 15 is OR of IPv6 extension hints over both headers
// - status bit 18 marks UDP packets with zero checksum word
// - error bit 3 IP sum error, bit 4 transport error, bit 5 reserved
// - over five descriptors sets error bit 6, excess not written
// - byte count in length bits 13:0, bits 25:14 zero
// - 8-bit packet kind code, ignored 12 written as reserved 0
// - 32-byte format writes four quad words, first two as 16-byte
// - spare descriptor writes zero length; it closes the packet only if its last flag is set or it is the fifth descriptor
// - zero UDP sum is no error on IPv4, transport error on IPv6
module rdwb_top (
	// Clock and reset
	input  wire logic                 I_CLK,
	input  wire logic                 I_RESET_N,
	// Buffer completions
	input  wire logic                 I_BUF_VALID,
	output logic                      O_BUF_READY,
	input  wire rdwb_pkg::rdwb_buf_s  I_BUF,
	input  wire rdwb_pkg::rdwb_pkt_s  I_PKT,
	// Descriptor writer
	output logic                      O_DESC_VALID,
	input  wire logic                 I_DESC_READY,
	output rdwb_pkg::rdwb_desc_s      O_DESC,
	// Status
	output logic                      O_OVERSIZE_DROP
);
	////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_sync;
	logic       rst_n;
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	////////////////////////////////////////////////////////////////
	// Descriptor count and oversize state
	rdwb_pkg::rdwb_state_e state, next_state;
	logic [2:0]            desc_idx, next_desc_idx;
	logic                  drop_flag, next_drop_flag;
	logic                  fill_ready, take, limit_hit, emit;

	assign take        = I_BUF_VALID && O_BUF_READY;
	assign limit_hit   = (desc_idx == `RDWB_MAX_DESC - 3'h1) && !I_BUF.last;
	// Excess buffers are consumed but never written
	assign emit        = I_BUF_VALID && (state == rdwb_pkg::RDWB_IDLE);
	assign O_BUF_READY = (state == rdwb_pkg::RDWB_DROP) || fill_ready;
	assign O_OVERSIZE_DROP = drop_flag;

	always_comb begin
		next_state     = state;
		next_desc_idx  = desc_idx;
		next_drop_flag = drop_flag;
		if (take) begin
			unique case (state)
				rdwb_pkg::RDWB_IDLE: begin
					if (I_BUF.last) begin
						next_desc_idx = 3'h0;
					end else begin
						next_desc_idx = desc_idx + 3'h1;
						if (limit_hit) begin
							next_state     = rdwb_pkg::RDWB_DROP;
							next_drop_flag = 1'b1;
						end
					end
				end
				// Dropped buffers vanish up to and including the packet's last one
				rdwb_pkg::RDWB_DROP: begin
					if (I_BUF.last) begin
						next_state     = rdwb_pkg::RDWB_IDLE;
						next_desc_idx  = 3'h0;
						next_drop_flag = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state     <= rdwb_pkg::RDWB_IDLE;
			desc_idx  <= 3'h0;
			drop_flag <= 1'b0;
		end else begin
			state     <= next_state;
			desc_idx  <= next_desc_idx;
			drop_flag <= next_drop_flag;
		end
	end

	////////////////////////////////////////////////////////////////
	// Field formatting
	function automatic logic [1:0] class_code(input logic [1:0] c);
		// Reserved code folds to unicast
		class_code = (c == 2'h3) ? `RDWB_CLS_UNI : c;
	endfunction : class_code

	function automatic logic [7:0] kind_code(input logic [7:0] k);
		// Codes software must skip become the reserved value
		kind_code = (k == `RDWB_KIND_IGNORE) ? `RDWB_KIND_RSV : k;
	endfunction : kind_code

	logic                 final_desc, trunc_last;
	logic [18:0]          status;
	logic [7:0]           errs;
	logic                 fcs_kept, udp0_err;
	rdwb_pkg::rdwb_desc_s desc;

	// The fifth descriptor closes an oversize packet
	assign trunc_last = limit_hit && (state == rdwb_pkg::RDWB_IDLE);
	assign final_desc = I_BUF.last || trunc_last;
	// Receive error beats strip; hardware-FCS loopback never keeps it
	assign fcs_kept   = !(I_PKT.is_local && I_PKT.local_hw_fcs)
		&& (I_PKT.rx_err || !I_PKT.fcs_remove);
	assign udp0_err   = I_PKT.is_udp && I_PKT.udp_sum_zero && I_PKT.is_v6;

	always_comb begin
		status = '0;
		errs   = '0;
		status[`RDWB_ST_DONE] = 1'b1;
		status[`RDWB_ST_LAST] = final_desc;
		if (final_desc) begin
			status[`RDWB_ST_TAGP]  = I_PKT.tag_stripped;
			status[`RDWB_ST_CHKD]  = I_PKT.is_ip && I_PKT.checks_done;
			status[`RDWB_ST_FCS]   = fcs_kept;
			status[`RDWB_ST_CLS_LO +: 2] = class_code(I_PKT.dest_class);
			status[`RDWB_ST_FLT_LO +: 2] = I_PKT.hash_hit ? `RDWB_FLT_HASH : `RDWB_FLT_NONE;
			status[`RDWB_ST_LOCAL] = I_PKT.is_local;
			// Each hint names an IPv6 header, so a v4 outer header still counts
			status[`RDWB_ST_V6ALT] = I_PKT.v6_ext_outer || I_PKT.v6_ext_inner;
			status[`RDWB_ST_UDP0]  = I_PKT.is_udp && I_PKT.udp_sum_zero;
			errs[`RDWB_ER_IP]      = I_PKT.checks_done && I_PKT.ip_sum_bad && !I_PKT.is_v6;
			errs[`RDWB_ER_L4]      = I_PKT.checks_done && (I_PKT.l4_bad || udp0_err);
			errs[`RDWB_ER_OVER]    = trunc_last;
		end
		desc       = '0;
		desc.fmt32 = I_BUF.fmt32;
		desc.qw1[18:0] = status;
		desc.qw1[`RDWB_QW1_ERR_LO +: 8] = errs;
		desc.qw1[`RDWB_QW1_KIND_LO +: 8] = final_desc ? kind_code(I_PKT.kind) : `RDWB_KIND_RSV;
		// Length bits 25:14 stay zero
		desc.qw1[`RDWB_QW1_LEN_LO +: 14] = I_BUF.dummy ? `RDWB_LEN_ZERO : I_BUF.byte_count;
		if (final_desc) begin
			desc.qw0[`RDWB_QW0_TAG_LO +: 16] = I_PKT.tag_stripped ? I_PKT.tag : 16'h0000;
			desc.qw0[`RDWB_QW0_FLT_LO +: 32] = I_PKT.hash_hit ? I_PKT.hash_sig : 32'h0000_0000;
			if (I_BUF.fmt32)
				desc.qw2[`RDWB_QW0_TAG_LO +: 16] = I_PKT.tag2;
		end
	end

	////////////////////////////////////////////////////////////////
	// Output buffer keeps ring order under stall
	rdwb_skid u_skid (
		.clk       (I_CLK),
		.rst_n     (rst_n),
		.in_valid  (emit),
		.in_ready  (fill_ready),
		.in_data   (desc),
		.out_valid (O_DESC_VALID),
		.out_ready (I_DESC_READY),
		.out_data  (O_DESC)
	);

	////////////////////////////////////////////////////////////////
	// Descriptors leaving per packet, for the five-descriptor limit
	logic [2:0] out_cnt, next_out_cnt;
	logic       out_pop;

	assign out_pop = O_DESC_VALID && I_DESC_READY;

	always_comb begin
		next_out_cnt = out_cnt;
		if (out_pop)
			next_out_cnt = O_DESC.qw1[`RDWB_ST_LAST] ? 3'h0 : out_cnt + 3'h1;
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			out_cnt <= 3'h0;
		else
			out_cnt <= next_out_cnt;
	end

	////////////////////////////////////////////////////////////////
	// Checks
	a_done_always: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID |-> O_DESC.qw1[`RDWB_ST_DONE])
		else $error("descriptor without done flag");
	a_mid_clean: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID && !O_DESC.qw1[`RDWB_ST_LAST] |-> O_DESC.qw0 == 64'h0)
		else $error("middle descriptor carries packet fields");
	a_last_mark: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && !I_BUF.last && !trunc_last |-> !desc.qw1[`RDWB_ST_LAST])
		else $error("last flag on a middle descriptor");
	a_rsv_zero: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID |-> O_DESC.qw1[8:5] == 4'h0 && O_DESC.qw1[63:52] == 12'h000)
		else $error("reserved bits set");
	a_class_legal: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID |-> O_DESC.qw1[`RDWB_ST_CLS_LO +: 2] != 2'h3)
		else $error("illegal destination class");
	a_hash_sel: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc && I_PKT.hash_hit |-> desc.qw1[`RDWB_ST_FLT_LO +: 2] == `RDWB_FLT_HASH
			&& desc.qw0[`RDWB_QW0_FLT_LO +: 32] == I_PKT.hash_sig)
		else $error("hash hit not reported");
	a_filter_pair: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID && O_DESC.qw1[`RDWB_ST_FLT_LO +: 2] == `RDWB_FLT_NONE
		|-> O_DESC.qw0[63:32] == 32'h0)
		else $error("filter word without hash selector");
	a_tag_pair: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID && !O_DESC.qw1[`RDWB_ST_TAGP] |-> O_DESC.qw0[31:16] == 16'h0)
		else $error("tag written without presence flag");
	a_tag_fill: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc && I_PKT.tag_stripped
		|-> desc.qw1[`RDWB_ST_TAGP] && desc.qw0[`RDWB_QW0_TAG_LO +: 16] == I_PKT.tag)
		else $error("stripped tag not written");
	a_chk_ip: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc && !I_PKT.is_ip |-> !desc.qw1[`RDWB_ST_CHKD])
		else $error("checks flag on a non ip packet");
	a_loop_fcs: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc && I_PKT.is_local && I_PKT.local_hw_fcs |-> !desc.qw1[`RDWB_ST_FCS])
		else $error("loopback posted with fcs");
	a_rxe_fcs: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc && I_PKT.rx_err && !I_PKT.is_local |-> desc.qw1[`RDWB_ST_FCS])
		else $error("fcs stripped despite receive error");
	a_local_flag: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc |-> desc.qw1[`RDWB_ST_LOCAL] == I_PKT.is_local)
		else $error("local origin flag wrong");
	a_v6_hint: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc && I_PKT.v6_ext_inner |-> desc.qw1[`RDWB_ST_V6ALT])
		else $error("inner header extension hint lost");
	a_udp_zero: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && final_desc && I_PKT.is_udp && I_PKT.udp_sum_zero |-> desc.qw1[`RDWB_ST_UDP0])
		else $error("zero udp sum flag missing");
	a_err_rsv: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID |-> O_DESC.qw1[`RDWB_QW1_ERR_LO +: 3] == 3'h0
			&& !O_DESC.qw1[`RDWB_QW1_ERR_LO + `RDWB_ER_RSV] && !O_DESC.qw1[`RDWB_QW1_ERR_LO + `RDWB_ER_TOP])
		else $error("reserved error bits set");
	a_v6_no_ipe: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && I_PKT.is_v6 |-> !desc.qw1[`RDWB_QW1_ERR_LO + `RDWB_ER_IP])
		else $error("ip sum error on ipv6 packet");
	a_over_drop: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		take && trunc_last |=> !emit && state == rdwb_pkg::RDWB_DROP && O_OVERSIZE_DROP)
		else $error("oversize packet not dropped");
	a_pkt_limit: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID |-> out_cnt < `RDWB_MAX_DESC)
		else $error("packet written past five descriptors");
	a_fifth_last: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID && out_cnt == `RDWB_MAX_DESC - 3'h1 |-> O_DESC.qw1[`RDWB_ST_LAST])
		else $error("fifth descriptor does not close the packet");
	a_len_byte: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && !I_BUF.dummy |-> desc.qw1[`RDWB_QW1_LEN_LO +: 14] == I_BUF.byte_count)
		else $error("buffer length not written");
	a_kind_skip: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID |-> O_DESC.qw1[`RDWB_QW1_KIND_LO +: 8] != `RDWB_KIND_IGNORE)
		else $error("ignored packet kind written");
	a_short_fmt: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		O_DESC_VALID && !O_DESC.fmt32 |-> O_DESC.qw2 == 64'h0 && O_DESC.qw3 == 64'h0)
		else $error("upper quad words set in short format");
	a_dummy_len: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && I_BUF.dummy |-> desc.qw1[`RDWB_QW1_LEN_LO +: 14] == 14'h0 && desc.qw1[`RDWB_ST_LAST])
		else $error("spare descriptor malformed");
	a_udp6_err: assert property (
		@(posedge I_CLK) disable iff (!rst_n)
		emit && I_BUF.last && I_PKT.checks_done && I_PKT.is_udp && I_PKT.udp_sum_zero && I_PKT.is_v6
		|-> desc.qw1[`RDWB_QW1_ERR_LO + `RDWB_ER_L4])
		else $error("zero udp sum on v6 not flagged");

	c_multi: cover property (@(posedge I_CLK) disable iff (!rst_n)
		take && !I_BUF.last ##[1:20] take && I_BUF.last);
	c_over: cover property (@(posedge I_CLK) disable iff (!rst_n) take && trunc_last);
	c_dummy: cover property (@(posedge I_CLK) disable iff (!rst_n) take && I_BUF.dummy);
	c_stall: cover property (@(posedge I_CLK) disable iff (!rst_n) I_BUF_VALID && !O_BUF_READY);
	c_wide: cover property (@(posedge I_CLK) disable iff (!rst_n) take && I_BUF.last && I_BUF.fmt32);
endmodule : rdwb_top

// ==== rdwb_sink.sv ====
// Descriptor writer model standing in for host memory.
// Assumes the formatter's valid/ready handshake on one clock.
module rdwb_sink (
	// Clock and stall control
	input  wire logic                 clk,
	input  wire logic                 stall,
	// Descriptor handshake
	input  wire logic                 valid,
	output logic                      ready,
	input  wire rdwb_pkg::rdwb_desc_s desc
);
	timeunit 1ns;
	timeprecision 100ps;
	rdwb_pkg::rdwb_desc_s q[$];
	// Stall holds ready low so the two-entry buffer fills
	assign ready = !stall;
	always @(posedge clk) begin
		if (valid && ready)
			q.push_back(desc);
	end
endmodule : rdwb_sink

// ==== test_rdwb_top.sv ====
// Self-checking bench for the descriptor write-back formatter.
// Assumes rdwb_pkg and the sink model are compiled first.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_rdwb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic                 I_CLK = 1'b0;
	logic                 I_RESET_N = 1'b0;
	logic                 I_BUF_VALID = 1'b0;
	logic                 O_BUF_READY;
	rdwb_pkg::rdwb_buf_s  bf = '0;
	rdwb_pkg::rdwb_pkt_s  pk = '0;
	rdwb_pkg::rdwb_pkt_s  p0;
	logic                 O_DESC_VALID;
	logic                 I_DESC_READY;
	rdwb_pkg::rdwb_desc_s O_DESC;
	logic                 O_OVERSIZE_DROP;
	logic                 stall = 1'b0;
	int                   n_fail = 0;
	int                   check_count = 0;
	int                   cycles = 0;
	rdwb_pkg::rdwb_desc_s exp[$];
	////////////////////////////////////////////////////////////////////////////
	rdwb_top i_dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_BUF_VALID(I_BUF_VALID),
		.O_BUF_READY(O_BUF_READY), .I_BUF(bf), .I_PKT(pk), .O_DESC_VALID(O_DESC_VALID),
		.I_DESC_READY(I_DESC_READY), .O_DESC(O_DESC), .O_OVERSIZE_DROP(O_OVERSIZE_DROP));
	rdwb_sink i_sink (.clk(I_CLK), .stall(stall), .valid(O_DESC_VALID), .ready(I_DESC_READY),
		.desc(O_DESC));
	always #25 I_CLK = ~I_CLK;
	// Ceiling well above the hundred or so cycles the scenarios need
	always @(posedge I_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	function automatic rdwb_pkg::rdwb_buf_s mb(logic l, logic dm, logic f, logic [13:0] n);
		return '{last: l, dummy: dm, fmt32: f, byte_count: n};
	endfunction : mb
	function automatic rdwb_pkg::rdwb_desc_s fmt(rdwb_pkg::rdwb_buf_s b, rdwb_pkg::rdwb_pkt_s p,
		logic fin, logic ovr);
		rdwb_pkg::rdwb_desc_s d;
		d = '0;
		d.fmt32 = b.fmt32;
		d.qw1[0] = 1'b1;
		d.qw1[1] = fin;
		d.qw1[51:38] = b.dummy ? 14'h0000 : b.byte_count;
		if (fin) begin
			d.qw0[31:16] = p.tag_stripped ? p.tag : 16'h0000;
			d.qw0[63:32] = p.hash_hit ? p.hash_sig : 32'h00000000;
			d.qw1[2] = p.tag_stripped;
			d.qw1[3] = p.is_ip && p.checks_done;
			d.qw1[4] = !(p.is_local && p.local_hw_fcs) && (p.rx_err || !p.fcs_remove);
			d.qw1[10:9] = (p.dest_class == 2'h3) ? 2'h0 : p.dest_class;
			d.qw1[13:12] = p.hash_hit ? 2'h3 : 2'h0;
			d.qw1[14] = p.is_local;
			d.qw1[15] = p.v6_ext_outer || p.v6_ext_inner;
			d.qw1[18] = p.is_udp && p.udp_sum_zero;
			d.qw1[22] = p.checks_done && p.ip_sum_bad && !p.is_v6;
			d.qw1[23] = p.checks_done && (p.l4_bad || (p.is_v6 && p.is_udp && p.udp_sum_zero));
			d.qw1[25] = ovr;
			d.qw1[37:30] = (p.kind == 8'h0C) ? 8'h00 : p.kind;
			if (b.fmt32)
				d.qw2[31:16] = p.tag2;
		end
		return d;
	endfunction : fmt
	////////////////////////////////////////////////////////////////////////////
	// Holds valid until taken; the caller lowers it, never this task
	task automatic put(rdwb_pkg::rdwb_buf_s b, rdwb_pkg::rdwb_pkt_s p, logic fin, logic ovr,
		logic keep);
		logic r;
		I_BUF_VALID = 1'b1;
		bf = b;
		pk = p;
		do begin
			@(negedge I_CLK);
			r = O_BUF_READY;
			@(posedge I_CLK);
		end while (r !== 1'b1);
		#2;
		if (keep)
			exp.push_back(fmt(b, p, fin, ovr));
	endtask : put
	task automatic drain(string nm);
		rdwb_pkg::rdwb_desc_s e;
		rdwb_pkg::rdwb_desc_s g;
		I_BUF_VALID = 1'b0;
		repeat (12) @(posedge I_CLK);
		#2;
		`CHK(nm, exp.size(), i_sink.q.size())
		while (exp.size() > 0 && i_sink.q.size() > 0) begin
			e = exp.pop_front();
			g = i_sink.q.pop_front();
			`CHK(nm, e, g)
		end
		exp.delete();
		i_sink.q.delete();
	endtask : drain
	////////////////////////////////////////////////////////////////////////////
	task automatic t_classes();
		rdwb_pkg::rdwb_pkt_s p;
		logic [7:0] kinds[4] = '{8'h01, 8'h0B, 8'h0C, 8'h00};
		for (int c = 0; c < 4; c++) begin
			p = p0;
			p.dest_class = 2'(c);
			p.tag_stripped = (c != 3);
			p.is_ip = (c != 1);
			p.v6_ext_outer = (c == 1);
			p.hash_hit = c[0];
			p.is_local = c[1];
			p.v6_ext_inner = (c == 2);
			p.kind = kinds[c];
			put(mb(1'b1, 1'b0, 1'b0, 14'h3FFF - 14'(c)), p, 1'b1, 1'b0, 1'b1);
		end
		drain("classes");
	endtask : t_classes
	task automatic t_multi();
		put(mb(1'b0, 1'b0, 1'b1, 14'h0064), p0, 1'b0, 1'b0, 1'b1);
		put(mb(1'b0, 1'b0, 1'b1, 14'h00C8), p0, 1'b0, 1'b0, 1'b1);
		put(mb(1'b1, 1'b0, 1'b1, 14'h0032), p0, 1'b1, 1'b0, 1'b1);
		put(mb(1'b0, 1'b0, 1'b0, 14'h012C), p0, 1'b0, 1'b0, 1'b1);
		put(mb(1'b1, 1'b1, 1'b0, 14'h1111), p0, 1'b1, 1'b0, 1'b1);
		drain("multi");
	endtask : t_multi
	task automatic t_errors();
		rdwb_pkg::rdwb_pkt_s p;
		for (int i = 0; i < 8; i++) begin
			p = p0;
			p.is_v6 = i[0];
			p.is_udp = 1'b1;
			p.udp_sum_zero = i[1];
			p.ip_sum_bad = i[2];
			p.rx_err = i[1];
			p.local_hw_fcs = i[2];
			p.is_local = i[2];
			p.fcs_remove = i[0];
			put(mb(1'b1, 1'b0, 1'b0, 14'h0040), p, 1'b1, 1'b0, 1'b1);
		end
		drain("errors");
	endtask : t_errors
	task automatic t_oversize();
		for (int i = 0; i < 5; i++)
			put(mb(1'b0, 1'b0, 1'b0, 14'h0100), p0, (i == 4), (i == 4), 1'b1);
		put(mb(1'b0, 1'b0, 1'b0, 14'h0100), p0, 1'b0, 1'b0, 1'b0);
		`CHK("drop", 1'b1, O_OVERSIZE_DROP)
		put(mb(1'b1, 1'b0, 1'b0, 14'h0100), p0, 1'b0, 1'b0, 1'b0);
		`CHK("drop end", 1'b0, O_OVERSIZE_DROP)
		put(mb(1'b1, 1'b0, 1'b0, 14'h0077), p0, 1'b1, 1'b0, 1'b1);
		drain("oversize");
	endtask : t_oversize
	task automatic t_stall();
		stall = 1'b1;
		put(mb(1'b1, 1'b0, 1'b0, 14'h0041), p0, 1'b1, 1'b0, 1'b1);
		put(mb(1'b1, 1'b0, 1'b1, 14'h0042), p0, 1'b1, 1'b0, 1'b1);
		I_BUF_VALID = 1'b0;
		repeat (3) @(negedge I_CLK);
		`CHK("full", 1'b0, O_BUF_READY)
		`CHK("held", 1'b1, O_DESC_VALID)
		@(posedge I_CLK);
		#2;
		stall = 1'b0;
		drain("stall");
	endtask : t_stall
	////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	initial begin
		p0 = '0;
		p0.tag_stripped = 1'b1;
		p0.tag = 16'hA5C3;
		p0.tag2 = 16'h1234;
		p0.is_ip = 1'b1;
		p0.checks_done = 1'b1;
		p0.fcs_remove = 1'b1;
		p0.dest_class = 2'h1;
		p0.hash_hit = 1'b1;
		p0.hash_sig = 32'h5EED0F17;
		p0.kind = 8'h0B;
		repeat (8) @(posedge I_CLK);
		#2;
		I_RESET_N = 1'b1;
		repeat (3) @(posedge I_CLK);
		#2;
		t_classes();
		t_multi();
		t_errors();
		t_oversize();
		t_stall();
		summarize();
	end
endmodule : test_rdwb_top
